// [rtl/oss_sequencer.sv]
// Offline service sequencer with Wishbone slave and diagnostic reporting.
// Notes on behaviour
// - Scan bit steps unit address each command
// - Without repeat, one command per start press
// - With repeat, issue continuously until stopped
// - Reposition after write, read and backward read, keep stored values
// - Write: back space or rewind, then erase
// - Read back spaces, backward read spaces
// - Stop-on-exception holds loop until cleared/inhibit
// - Reverse maps write/read to backward read, swaps space codes on exception
// - Erase/nop to backward read, marks to back_space_file
// - Rewind-on-exception issues rewind
// - Rewind plus reverse also toggles speed
// - Unit check sets error flag and lamp
// - Reposition on check, ignore repositioning errors
// - Stop-on-check holds loop until cleared/inhibit
// - Both check bits: reposition, recheck holds
// - Inhibit blocks start, releases stop, keeps repeat
// - Checkout pulse after every eight scanned units
// - Online error stores code, disconnects on selection
// - Selective reset clears disconnect, sets error flag
// - Error flag answers non-sense with check
// - Self test on power-on and any reset source
module oss_sequencer (
  // Clock, reset, enable
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       enable_i,
  // Wishbone classic slave
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]     wb_dat_o,
  output logic            wb_ack_o,
  // Panel
  input  wire logic       offline_i,
  input  wire logic       start_press_i,
  input  wire logic       start_inhibit_i,
  input  wire logic       panel_reset_i,
  output logic            error_lamp_o,
  // Tape command port
  output logic            cmd_valid_o,
  output logic [7:0]      cmd_code_o,
  output logic [2:0]      cmd_unit_o,
  input  wire logic       end_valid_i,
  input  wire logic       end_uex_i,
  input  wire logic       end_uck_i,
  input  wire logic       id_burst_check_i,
  // Diagnostics and channel
  input  wire logic       diag_error_i,
  input  wire logic [15:0] fru_code_i,
  input  wire logic       initial_selection_i,
  input  wire logic       selective_reset_i,
  input  wire logic       system_reset_i,
  input  wire logic       chan_cmd_i,
  input  wire logic [7:0] chan_code_i,
  output logic            chan_uck_o,
  output logic            disconnect_in_o,
  output logic [15:0]     fru_code_o,
  output logic            checkout_o,
  output logic            self_test_o
);
  // ==========================================================
  // State
  typedef struct packed {
    oss_pkg::oss_state_e st;
    logic [7:0]  diag0, diag1, diag2, diag3;
    logic [7:0]  ctl, cmd;
    logic [2:0]  unit;
    logic [7:0]  cur;     // code now in flight
    logic [1:0]  step;    // repositioning step
    logic        chk_rep; // repositioning caused by unit check
    logic        hold_uck;
    logic        pend;    // hardware command after exception
    logic [7:0]  pend_code;
    logic        speed_next;
    logic [2:0]  scanned;
    logic        uex_l, uck_l, idb_l, rep_run; // status copy, repeat armed
    logic        error_flag, wait_sel, disc, chan_uck, ack;
    logic [31:0] rdat;
    logic [15:0] fru;
    logic        checkout, self_test, offl_q, first;
  } oss_s;
  oss_s s_q, s_d;

  function automatic logic [7:0] oss_reverse(input logic [7:0] c);
    case (c)
      oss_pkg::C_WRITE, oss_pkg::C_READ,
      oss_pkg::C_ERASE, oss_pkg::C_NOP: oss_reverse = oss_pkg::C_BRD;
      oss_pkg::C_BRD:   oss_reverse = oss_pkg::C_READ;
      oss_pkg::C_SPACE: oss_reverse = oss_pkg::C_BSP;
      oss_pkg::C_BSP:   oss_reverse = oss_pkg::C_SPACE;
      oss_pkg::C_WTM,
      oss_pkg::C_DSE:   oss_reverse = oss_pkg::C_BACK_SPACE_FILE;
      default:          oss_reverse = c;
    endcase
  endfunction : oss_reverse

  logic acc;
  logic [7:0] ctl;
  logic inh, repos_needed;
  assign acc = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign ctl = s_q.ctl;
  assign inh = start_inhibit_i;
  assign repos_needed = (s_q.cmd == oss_pkg::C_WRITE) ||
                        (s_q.cmd == oss_pkg::C_READ) ||
                        (s_q.cmd == oss_pkg::C_BRD);

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.checkout = 1'b0;
    s_d.self_test = 1'b0;
    s_d.chan_uck = 1'b0;
    s_d.offl_q = offline_i;
    s_d.first = 1'b0;
    if (s_q.first || system_reset_i || selective_reset_i ||
        panel_reset_i || (offline_i != s_q.offl_q)) begin
      s_d.self_test = 1'b1;
    end
    // Register bus, ack registered one cycle after the request
    if (acc) begin
      s_d.ack = 1'b1;
      s_d.rdat = '0;
      if (wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          oss_pkg::ADDR_DIAG0:   s_d.diag0 = wb_dat_i[7:0];
          oss_pkg::ADDR_DIAG0 + 8'h04: s_d.diag1 = wb_dat_i[7:0];
          oss_pkg::ADDR_DIAG0 + 8'h08: s_d.diag2 = wb_dat_i[7:0];
          oss_pkg::ADDR_DIAG0 + 8'h0c: s_d.diag3 = wb_dat_i[7:0];
          oss_pkg::ADDR_CONTROL: s_d.ctl = wb_dat_i[7:0];
          oss_pkg::ADDR_COMMAND: s_d.cmd = wb_dat_i[7:0];
          oss_pkg::ADDR_UNIT:    s_d.unit = wb_dat_i[2:0];
          default: ;
        endcase
      end
      case (wb_adr_i)
        oss_pkg::ADDR_DIAG0:   s_d.rdat = {24'h0, s_q.diag0};
        oss_pkg::ADDR_DIAG0 + 8'h04: s_d.rdat = {24'h0, s_q.diag1};
        oss_pkg::ADDR_DIAG0 + 8'h08: s_d.rdat = {24'h0, s_q.diag2};
        oss_pkg::ADDR_DIAG0 + 8'h0c: s_d.rdat = {24'h0, s_q.diag3};
        oss_pkg::ADDR_CONTROL: s_d.rdat = {24'h0, s_q.ctl};
        oss_pkg::ADDR_COMMAND: s_d.rdat = {24'h0, s_q.cmd};
        oss_pkg::ADDR_UNIT:    s_d.rdat = {29'h0, s_q.unit};
        oss_pkg::ADDR_STATUS:
          s_d.rdat = {21'h0, s_q.st, 1'b0, s_q.hold_uck, s_q.wait_sel,
                      s_q.disc, s_q.speed_next, s_q.pend,
                      s_q.error_flag, s_q.st == oss_pkg::ST_HOLD};
        default: s_d.rdat = '0;
      endcase
    end
    // Offline sequencer
    case (s_q.st)
      oss_pkg::ST_IDLE: begin
        // one command per press, inhibited presses dropped
        if (offline_i && start_press_i && !inh) begin
          s_d.st = oss_pkg::ST_ISSUE;
          s_d.cur = s_q.cmd;
          s_d.step = 2'd0;
          s_d.rep_run = 1'b1;
        end
      end
      oss_pkg::ST_ISSUE: s_d.st = oss_pkg::ST_WAIT;
      oss_pkg::ST_WAIT: begin
        if (end_valid_i) begin
          // unit check lights error flag; new status resets lamp
          s_d.error_flag = end_uck_i;
          // Qualifiers stand only with the strobe, so keep a copy
          s_d.uex_l = end_uex_i;
          s_d.uck_l = end_uck_i;
          s_d.idb_l = id_burst_check_i;
          s_d.st = oss_pkg::ST_EVAL;
          if (s_q.step != 2'd0 || s_q.pend) begin
            s_d.st = oss_pkg::ST_REPOS;
          end
          // new check during repositioning stops the loop when stop-on-check and reposition-on-check are both set
          if (s_q.step != 2'd0 && end_uck_i &&
              ctl[oss_pkg::B_STOP_ON_CHECK] && ctl[oss_pkg::B_REPOSITION_ON_CHECK]) begin
            s_d.st = oss_pkg::ST_HOLD;
            s_d.hold_uck = 1'b1;
            s_d.step = 2'd0;
            s_d.pend = 1'b0;
          end
        end
      end
      oss_pkg::ST_EVAL: begin
        s_d.st = oss_pkg::ST_IDLE;
        if (s_q.uex_l && ctl[oss_pkg::B_STOP_ON_EXCEPTION]) begin
          // exception stop loop, other exception bits ignored
          s_d.st = oss_pkg::ST_HOLD;
          s_d.hold_uck = 1'b0;
        end else if (s_q.uck_l && ctl[oss_pkg::B_STOP_ON_CHECK] &&
                     !ctl[oss_pkg::B_REPOSITION_ON_CHECK]) begin
          s_d.st = oss_pkg::ST_HOLD;
          s_d.hold_uck = 1'b1;
        end else begin
          if (s_q.uex_l && ctl[oss_pkg::B_REVERSE_ON_EXCEPTION] &&
              !ctl[oss_pkg::B_REWIND_ON_EXCEPTION]) begin
            s_d.cmd = oss_reverse(s_q.cmd);
          end
          if (s_q.uex_l && ctl[oss_pkg::B_REWIND_ON_EXCEPTION]) begin
            s_d.pend = 1'b1;
            s_d.pend_code = oss_pkg::C_REW;
            s_d.speed_next = ctl[oss_pkg::B_REVERSE_ON_EXCEPTION];
          end
          if (repos_needed && (ctl[oss_pkg::B_RPS] ||
              (s_q.uck_l && ctl[oss_pkg::B_REPOSITION_ON_CHECK]))) begin
            s_d.step = 2'd1;
            s_d.chk_rep = s_q.uck_l && !ctl[oss_pkg::B_RPS];
          end
          if (s_d.pend || s_d.step != 2'd0) begin
            s_d.st = oss_pkg::ST_REPOS;
          end else begin
            s_d.st = oss_pkg::ST_REPOS;
          end
        end
      end
      oss_pkg::ST_REPOS: begin
        // rewind once, then drop the code so it is not reissued
        if (s_q.pend && s_q.pend_code == oss_pkg::C_REW) begin
          s_d.pend_code = oss_pkg::RST8;
          s_d.cur = oss_pkg::C_REW;
          s_d.st = oss_pkg::ST_ISSUE;
        end else if (s_q.pend && s_q.speed_next) begin
          s_d.speed_next = 1'b0;
          s_d.cur = oss_pkg::C_SPEED;
          s_d.st = oss_pkg::ST_ISSUE;
        end else if (s_q.step == 2'd1) begin
          // write repositions by back space or rewind
          // read back spaces, backward read spaces
          // Step 3 marks the last repositioning move in flight
          s_d.pend = 1'b0;
          s_d.step = 2'd3;
          s_d.st = oss_pkg::ST_ISSUE;
          if (s_q.cmd == oss_pkg::C_WRITE) begin
            s_d.step = 2'd2;
            s_d.cur = s_q.idb_l ? oss_pkg::C_REW
                                       : oss_pkg::C_BSP;
          end else if (s_q.cmd == oss_pkg::C_READ) begin
            s_d.cur = oss_pkg::C_BSP;
          end else begin
            s_d.cur = oss_pkg::C_SPACE;
          end
        end else if (s_q.step == 2'd2) begin
          s_d.step = 2'd3;
          s_d.cur = oss_pkg::C_ERASE;
          s_d.st = oss_pkg::ST_ISSUE;
        end else begin
          s_d.step = 2'd0;
          s_d.pend = 1'b0;
          s_d.chk_rep = 1'b0;
          s_d.st = oss_pkg::ST_IDLE;
          // step unit address after each command
          if (ctl[oss_pkg::B_SCAN]) begin
            s_d.unit = s_q.unit + 3'd1;
            s_d.scanned = s_q.scanned + 3'd1;
            if (s_q.scanned == 3'(oss_pkg::SCAN_WRAP - 1)) begin
              s_d.checkout = 1'b1;
            end
          end
          // repeat keeps issuing; inhibit pauses only
          if (ctl[oss_pkg::B_REPEAT] && !inh && offline_i) begin
            s_d.cur = s_d.cmd;
            s_d.st = oss_pkg::ST_ISSUE;
          end
        end
      end
      oss_pkg::ST_HOLD: begin
        if (inh || (s_q.hold_uck ? !ctl[oss_pkg::B_STOP_ON_CHECK]
                                 : !ctl[oss_pkg::B_STOP_ON_EXCEPTION])) begin
          s_d.st = oss_pkg::ST_IDLE;
        end
      end
      default: s_d.st = oss_pkg::ST_IDLE;
    endcase
    // repeat resumes from idle once inhibit drops
    if (s_q.st == oss_pkg::ST_IDLE && s_d.st == oss_pkg::ST_IDLE &&
        ctl[oss_pkg::B_REPEAT] && s_q.rep_run && !inh && offline_i) begin
      s_d.cur = s_q.cmd;
      s_d.st = oss_pkg::ST_ISSUE;
    end
    // repeat needs a press first and ends when its bit clears
    if (!ctl[oss_pkg::B_REPEAT]) begin
      s_d.rep_run = 1'b0;
    end
    // online diagnostic error stores code, waits selection
    if (diag_error_i && !offline_i) begin
      s_d.fru = fru_code_i;
      s_d.wait_sel = 1'b1;
    end else if (s_q.wait_sel && initial_selection_i) begin
      s_d.wait_sel = 1'b0;
      s_d.disc = 1'b1;
    end
    // selective reset clears disconnect, flags error
    if (selective_reset_i && s_q.disc) begin
      s_d.disc = 1'b0;
      s_d.error_flag = 1'b1;
    end
    // error flag answers non-sense commands with check
    if (chan_cmd_i && s_q.error_flag && chan_code_i != oss_pkg::C_SENSE) begin
      s_d.chan_uck = 1'b1;
      s_d.error_flag = 1'b0;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.first <= 1'b1;
    end else if (enable_i) begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign wb_ack_o        = s_q.ack;
  assign wb_dat_o        = s_q.rdat;
  assign error_lamp_o    = s_q.error_flag;
  assign cmd_valid_o     = (s_q.st == oss_pkg::ST_ISSUE);
  assign cmd_code_o      = s_q.cur;
  assign cmd_unit_o      = s_q.unit;
  assign chan_uck_o      = s_q.chan_uck;
  assign disconnect_in_o = s_q.disc;
  assign fru_code_o      = s_q.fru;
  assign checkout_o      = s_q.checkout;
  assign self_test_o     = s_q.self_test;

  // ==========================================================
  // Checks
  a_hold_release: assert property (@(posedge clock_i) disable iff
    (!rst_n_i) (enable_i && s_q.st == oss_pkg::ST_HOLD && inh) |=>
    s_q.st == oss_pkg::ST_IDLE) else $error("hold not released");
  a_disc_clear: assert property (@(posedge clock_i) disable iff
    (!rst_n_i) (enable_i && selective_reset_i && s_q.disc) |=>
    (!s_q.disc && s_q.error_flag)) else $error("disconnect kept");
  a_issue_single: assert property (@(posedge clock_i) disable iff
    (!rst_n_i) (enable_i && cmd_valid_o) |=> !cmd_valid_o)
    else $error("issue stuck");
  a_ack_one: assert property (@(posedge clock_i) disable iff
    (!rst_n_i) wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_uck_lamp: assert property (@(posedge clock_i) disable iff
    (!rst_n_i) (enable_i && s_q.st == oss_pkg::ST_WAIT && end_valid_i &&
    end_uck_i && !chan_cmd_i) |=> error_lamp_o)
    else $error("lamp not lit");
  a_chan_uck: assert property (@(posedge clock_i) disable iff
    (!rst_n_i) (enable_i && chan_cmd_i && s_q.error_flag &&
    chan_code_i != oss_pkg::C_SENSE) |=> chan_uck_o)
    else $error("no check answer");
  a_self_test: assert property (@(posedge clock_i) disable iff
    (!rst_n_i) (enable_i && system_reset_i) |=> self_test_o)
    else $error("no self test");
  a_cmd_kept: assert property (@(posedge clock_i) disable iff
    (!rst_n_i) (enable_i && s_q.st == oss_pkg::ST_REPOS && !acc) |=>
    $stable(s_q.cmd)) else $error("code changed");
endmodule : oss_sequencer

// [rtl/oss_pkg.sv]
// Package for the offline service sequencer: map, fields, command codes.
package oss_pkg;
  // ==========================================================
  // Register byte addresses (word aligned on Wishbone)
  localparam logic [7:0] ADDR_DIAG0   = 8'he0;
  localparam logic [7:0] ADDR_CONTROL = 8'hf0;
  localparam logic [7:0] ADDR_COMMAND = 8'hf4;
  localparam logic [7:0] ADDR_UNIT    = 8'hf8;
  localparam logic [7:0] ADDR_STATUS  = 8'hfc;
  localparam int         DIAG_BYTES   = 4;
  // ==========================================================
  // Control bit positions (bit 0 is the MSB in the old numbering)
  localparam int B_STOP_ON_CHECK = 7;
  localparam int B_REPOSITION_ON_CHECK = 6;
  localparam int B_STOP_ON_EXCEPTION = 5;
  localparam int B_REWIND_ON_EXCEPTION = 4;
  localparam int B_REVERSE_ON_EXCEPTION = 3;
  localparam int B_RPS     = 2;
  localparam int B_REPEAT  = 1;
  localparam int B_SCAN    = 0;
  localparam int UNIT_W    = 3;
  localparam int SCAN_WRAP = 8;
  // ==========================================================
  // Command codes
  localparam logic [7:0] C_WRITE = 8'h01;
  localparam logic [7:0] C_READ  = 8'h02;
  localparam logic [7:0] C_NOP   = 8'h03;
  localparam logic [7:0] C_BRD   = 8'h0c;
  localparam logic [7:0] C_ERASE = 8'h17;
  localparam logic [7:0] C_WTM   = 8'h1f;
  localparam logic [7:0] C_BSP   = 8'h27;
  localparam logic [7:0] C_BACK_SPACE_FILE  = 8'h2f;
  localparam logic [7:0] C_SPACE = 8'h37;
  localparam logic [7:0] C_DSE   = 8'h97;
  localparam logic [7:0] C_REW   = 8'h07;
  localparam logic [7:0] C_SPEED = 8'hdb;
  localparam logic [7:0] C_SENSE = 8'h04;
  localparam logic [7:0] RST8    = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ISSUE, ST_WAIT, ST_EVAL, ST_REPOS, ST_HOLD
  } oss_state_e;
endpackage : oss_pkg

// [test/oss_tape_model.sv]
// Behavioural tape unit bank that answers each command with end status.
module oss_tape_model (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Command strobe from the sequencer
  input  wire logic       cmd_valid_i,
  // Bench controls: answer delay and faults to report
  input  wire logic [3:0] lat_i,
  input  wire logic       uex_i,
  input  wire logic       uck_i,
  input  wire logic       idb_i,
  // End status towards the sequencer
  output logic            end_valid_o,
  output logic            end_uex_o,
  output logic            end_uck_o,
  output logic            idb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Answer timing
  logic [3:0] cnt_q;
  logic       busy_q;
  logic [2:0] flt_q;
  // Faults latch with the command, so the bench may move on early
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q       <= 4'h0;
      busy_q      <= 1'b0;
      flt_q       <= 3'h0;
      end_valid_o <= 1'b0;
    end else begin
      end_valid_o <= 1'b0;
      if (cmd_valid_i) begin
        busy_q <= 1'b1;
        cnt_q  <= lat_i;
        flt_q  <= {uex_i, uck_i, idb_i};
      end else if (busy_q && cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (busy_q) begin
        busy_q      <= 1'b0;
        end_valid_o <= 1'b1;
      end
    end
  end
  // Qualifiers are not held: outside the pulse they show the inverse
  assign end_uex_o = end_valid_o ? flt_q[2] : ~flt_q[2];
  assign end_uck_o = end_valid_o ? flt_q[1] : ~flt_q[1];
  assign idb_o     = end_valid_o ? flt_q[0] : ~flt_q[0];
endmodule : oss_tape_model

// [test/tb_top.sv]
// Self-checking bench for the offline service sequencer.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Stimulus and observation
  typedef struct packed {
    logic [7:0]  ctl;
    logic [7:0]  cod;
    logic [1:0]  flt;
    logic        idb;
    logic [1:0]  n;
    logic [23:0] seq;
    logic [7:0]  sto;
    logic        lmp;
  } oss_row_s;
  logic        clock_i, rst_n_i, cyc, stb, we, offline, start, inhibit;
  logic        preset, derr, initial_selection_flag, srst, sysrst, ccmd, f_uex, f_uck, f_idb;
  logic [7:0]  adr, ccode, cmd_code_o;
  logic [31:0] dat, rd, wb_dat_o;
  logic [15:0] fru, fru_code_o;
  logic [3:0]  lat;
  logic [2:0]  cmd_unit_o;
  logic        wb_ack_o, error_lamp_o, cmd_valid_o, chan_uck_o, dis_o;
  logic        checkout_o, self_test_o, ev, eu, ec, ei;
  int          miscompares, tests_run, fl, n_ck, n_st, n_uk, m;
  logic [10:0] q[$];
  oss_row_s    rows[19];
  oss_row_s    r;
  oss_sequencer u_oss_sequencer (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .enable_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .offline_i(offline), .start_press_i(start),
    .start_inhibit_i(inhibit), .panel_reset_i(preset),
    .error_lamp_o(error_lamp_o), .cmd_valid_o(cmd_valid_o),
    .cmd_code_o(cmd_code_o), .cmd_unit_o(cmd_unit_o), .end_valid_i(ev),
    .end_uex_i(eu), .end_uck_i(ec), .id_burst_check_i(ei),
    .diag_error_i(derr), .fru_code_i(fru), .initial_selection_i(initial_selection_flag),
    .selective_reset_i(srst), .system_reset_i(sysrst), .chan_cmd_i(ccmd),
    .chan_code_i(ccode), .chan_uck_o(chan_uck_o), .disconnect_in_o(dis_o),
    .fru_code_o(fru_code_o), .checkout_o(checkout_o),
    .self_test_o(self_test_o));
  oss_tape_model u_oss_tape_model (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_o),
    .lat_i(lat), .uex_i(f_uex && fl > 0), .uck_i(f_uck && fl > 0),
    .idb_i(f_idb), .end_valid_o(ev), .end_uex_o(eu), .end_uck_o(ec),
    .idb_o(ei));
  // Free-running 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Log commands and count pulses; faults are spent per command
  always @(posedge clock_i) begin
    if (cmd_valid_o === 1'b1) begin
      q.push_back({cmd_unit_o, cmd_code_o});
      if (fl > 0) fl <= fl - 1;
    end
    if (checkout_o === 1'b1) n_ck++;
    if (self_test_o === 1'b1) n_st++;
    if (chan_uck_o === 1'b1) n_uk++;
  end
  // ==========================================================
  // Tasks
  task automatic cy(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cy
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // Classic single cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, d);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 40);
    if (k >= 40) chk("wb_ack", 32'h1, 32'h0);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock_i);
  endtask : wb
  task automatic setup(input logic [7:0] c, cd, u);
    wb(1'b1, oss_pkg::ADDR_CONTROL, c);
    wb(1'b1, oss_pkg::ADDR_COMMAND, cd);
    wb(1'b1, oss_pkg::ADDR_UNIT, u);
    q.delete();
  endtask : setup
  // Press start, then poll until idle or holding
  task automatic run;
    int k;
    start <= 1'b1;
    cy(1);
    start <= 1'b0;
    cy(3);
    k = 0;
    do begin
      wb(1'b0, oss_pkg::ADDR_STATUS, 8'h00);
      k++;
    end while (rd[10:8] != oss_pkg::ST_IDLE &&
               rd[10:8] != oss_pkg::ST_HOLD && k < 60);
  endtask : run
  task automatic hold(input logic [7:0] c, input logic x, k, inh,
                      input int nf, n);
    setup(c, oss_pkg::C_READ, 8'h01);
    {f_uex, f_uck} = {x, k};
    fl = nf;
    run();
    chk("hold_cmds", 32'(n), 32'(q.size()));
    chk("holding", 32'h1, {31'h0, rd[0]});
    if (inh) inhibit <= 1'b1;
    else wb(1'b1, oss_pkg::ADDR_CONTROL, 8'h00);
    cy(5);
    wb(1'b0, oss_pkg::ADDR_STATUS, 8'h00);
    chk("released", 32'h0, {31'h0, rd[0]});
    inhibit <= 1'b0;
    wb(1'b1, oss_pkg::ADDR_CONTROL, 8'h00);
    wb(1'b0, oss_pkg::ADDR_COMMAND, 8'h00);
    chk("hold_code", 32'(oss_pkg::C_READ), rd);
    $display("hold test %0h done", c);
  endtask : hold
  task automatic results;
    $display("Tests run %0d, miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  // Hang guard, sized well above the expected run
  initial begin
    repeat (40000) @(posedge clock_i);
    miscompares++;
    $display("[FAIL] watchdog expected end seen hang");
    results();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {cyc, stb, we, start, inhibit, preset, derr} = '0;
    {initial_selection_flag, srst, sysrst, ccmd, f_uex, f_uck, f_idb} = '0;
    {adr, ccode, dat, fru, lat, fl, n_ck, n_st, n_uk} = '0;
    offline = 1'b1;
    rst_n_i = 1'b0;
    rows = '{
      '{8'h08, 8'h01, 2'd2, 1'b0, 2'd1, 24'h010000, 8'h0c, 1'b0},
      '{8'h08, 8'h02, 2'd2, 1'b0, 2'd1, 24'h020000, 8'h0c, 1'b0},
      '{8'h08, 8'h0c, 2'd2, 1'b0, 2'd1, 24'h0c0000, 8'h02, 1'b0},
      '{8'h08, 8'h37, 2'd2, 1'b0, 2'd1, 24'h370000, 8'h27, 1'b0},
      '{8'h08, 8'h27, 2'd2, 1'b0, 2'd1, 24'h270000, 8'h37, 1'b0},
      '{8'h08, 8'h17, 2'd2, 1'b0, 2'd1, 24'h170000, 8'h0c, 1'b0},
      '{8'h08, 8'h03, 2'd2, 1'b0, 2'd1, 24'h030000, 8'h0c, 1'b0},
      '{8'h08, 8'h1f, 2'd2, 1'b0, 2'd1, 24'h1f0000, 8'h2f, 1'b0},
      '{8'h08, 8'h97, 2'd2, 1'b0, 2'd1, 24'h970000, 8'h2f, 1'b0},
      '{8'h08, 8'h07, 2'd2, 1'b0, 2'd1, 24'h070000, 8'h07, 1'b0},
      '{8'h04, 8'h01, 2'd0, 1'b0, 2'd3, 24'h012717, 8'h01, 1'b0},
      '{8'h04, 8'h01, 2'd0, 1'b1, 2'd3, 24'h010717, 8'h01, 1'b0},
      '{8'h04, 8'h02, 2'd2, 1'b0, 2'd2, 24'h022700, 8'h02, 1'b0},
      '{8'h04, 8'h0c, 2'd0, 1'b0, 2'd2, 24'h0c3700, 8'h0c, 1'b0},
      '{8'h04, 8'h03, 2'd0, 1'b0, 2'd1, 24'h030000, 8'h03, 1'b0},
      '{8'h00, 8'h02, 2'd3, 1'b0, 2'd1, 24'h020000, 8'h02, 1'b1},
      '{8'h10, 8'h02, 2'd2, 1'b0, 2'd2, 24'h020700, 8'h02, 1'b0},
      '{8'h18, 8'h02, 2'd2, 1'b0, 2'd3, 24'h0207db, 8'h02, 1'b0},
      '{8'h40, 8'h02, 2'd1, 1'b0, 2'd2, 24'h022700, 8'h02, 1'b0}};
    cy(10);
    rst_n_i <= 1'b1;
    cy(4);
    chk("self_test_power_on", 32'h1, 32'(n_st));
    chk("lamp_reset", 32'h0, {31'h0, error_lamp_o});
    wb(1'b0, oss_pkg::ADDR_CONTROL, 8'h00);
    chk("control_reset", 32'(oss_pkg::RST8), rd);
    wb(1'b1, 8'h80, 8'h3c);
    wb(1'b0, 8'h80, 8'h00);
    chk("unmapped", 32'h0, rd);
    // Flags are set once and left alone while offline
    wb(1'b1, oss_pkg::ADDR_DIAG0, 8'h5a);
    wb(1'b0, oss_pkg::ADDR_DIAG0, 8'h00);
    chk("diag0", 32'h5a, rd);
    $display("reset and map test done");
    for (int i = 0; i < 19; i++) begin
      r = rows[i];
      lat = i[0] ? 4'd1 : 4'd7;
      {f_uex, f_uck} = r.flt;
      f_idb = r.idb;
      fl = 1;
      setup(r.ctl, r.cod, 8'(i[2:0]));
      run();
      chk("cmd_count", 32'(r.n), 32'(q.size()));
      for (int j = 0; j < r.n && j < q.size(); j++)
        chk("cmd", 32'({i[2:0], r.seq[23-8*j -: 8]}), 32'(q[j]));
      wb(1'b0, oss_pkg::ADDR_COMMAND, 8'h00);
      chk("stored_code", 32'(r.sto), rd);
      wb(1'b0, oss_pkg::ADDR_UNIT, 8'h00);
      chk("stored_unit", 32'(i[2:0]), rd);
      chk("lamp", 32'(r.lmp), {31'h0, error_lamp_o});
      $display("row %0d done", i);
    end
    {f_uex, f_uck, f_idb} = '0;
    setup(8'h01, oss_pkg::C_NOP, 8'h00);
    n_ck = 0;
    for (int k = 0; k < 8; k++) run();
    chk("one_per_press", 32'h8, 32'(q.size()));
    for (int k = 0; k < 8; k++) chk("scan_unit", 32'(k), 32'(q[k][10:8]));
    wb(1'b0, oss_pkg::ADDR_UNIT, 8'h00);
    chk("scan_wrap", 32'h0, rd);
    chk("checkout", 32'h1, 32'(n_ck));
    $display("scan test done");
    setup(8'h02, oss_pkg::C_NOP, 8'h02);
    start <= 1'b1;
    cy(1);
    start <= 1'b0;
    cy(100);
    chk("repeat_runs", 32'h1, 32'(q.size() > 3));
    inhibit <= 1'b1;
    cy(30);
    m = q.size();
    cy(50);
    chk("inhibit_stops", 32'(m), 32'(q.size()));
    wb(1'b0, oss_pkg::ADDR_CONTROL, 8'h00);
    chk("repeat_kept", 32'h2, rd);
    inhibit <= 1'b0;
    cy(60);
    chk("repeat_resumes", 32'h1, 32'(q.size() > m));
    setup(8'h00, oss_pkg::C_NOP, 8'h00);
    cy(40);
    q.delete();
    inhibit <= 1'b1;
    run();
    chk("inhibit_blocks", 32'h0, 32'(q.size()));
    inhibit <= 1'b0;
    $display("repeat and inhibit test done");
    hold(8'h20, 1'b1, 1'b0, 1'b1, 1, 1);
    hold(8'h38, 1'b1, 1'b0, 1'b0, 1, 1);
    hold(8'h80, 1'b0, 1'b1, 1'b0, 1, 1);
    hold(8'hc0, 1'b0, 1'b1, 1'b1, 2, 2);
    offline <= 1'b0;
    fru <= 16'h1234;
    derr <= 1'b1;
    cy(1);
    derr <= 1'b0;
    cy(4);
    chk("no_early_disc", 32'h0, {31'h0, dis_o});
    initial_selection_flag <= 1'b1;
    cy(1);
    initial_selection_flag <= 1'b0;
    cy(4);
    chk("disconnect", 32'h1, {31'h0, dis_o});
    chk("fru", 32'h1234, {16'h0, fru_code_o});
    n_st = 0;
    srst <= 1'b1;
    cy(1);
    srst <= 1'b0;
    cy(4);
    chk("disc_clear", 32'h0, {31'h0, dis_o});
    chk("error_flag_set", 32'h1, {31'h0, error_lamp_o});
    chk("fru_kept", 32'h1234, {16'h0, fru_code_o});
    chk("self_test_srst", 32'h1, 32'(n_st));
    n_uk = 0;
    ccode <= oss_pkg::C_SENSE;
    ccmd <= 1'b1;
    cy(1);
    ccmd <= 1'b0;
    cy(4);
    chk("sense_ok", 32'h0, 32'(n_uk));
    ccode <= oss_pkg::C_READ;
    ccmd <= 1'b1;
    cy(1);
    ccmd <= 1'b0;
    cy(4);
    chk("bus_out_check", 32'h1, 32'(n_uk));
    chk("error_flag_cleared", 32'h0, {31'h0, error_lamp_o});
    n_st = 0;
    sysrst <= 1'b1;
    cy(1);
    sysrst <= 1'b0;
    cy(4);
    preset <= 1'b1;
    cy(1);
    preset <= 1'b0;
    cy(4);
    offline <= 1'b1;
    cy(4);
    chk("self_test_sources", 32'h3, 32'(n_st));
    $display("diagnostic report test done");
    results();
  end
endmodule : tb_top
